/* File: tb/sermap_far_model.sv */
// Purpose: Far side model: pulled-up bus lines and remote receiver lock
// Assumes: SDA is held low only while the bench asks for a hung bus
// Notes: lock_id is scrambled every cycle while the link is down
`default_nettype none
module sermap_far_model (
    input wire logic ref_clk,
    input wire logic scl_oe,
    input wire logic hang,
    input wire logic lock_req,
    input wire logic [6:0] id_req,
    output logic scl_in,
    output logic sda_in,
    output logic rx_lock,
    output logic [6:0] lock_id
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open-drain lines, pull-up wins unless someone pulls low
    assign scl_in = ~scl_oe;
    assign sda_in = ~hang;
    // Lock follows the request, address only meaningful while locked
    initial
    begin
        rx_lock = 1'b0;
        lock_id = 7'h55;
    end
    always @(posedge ref_clk)
    begin
        rx_lock <= lock_req;
        lock_id <= lock_req ? id_req : ~lock_id;
    end
endmodule : sermap_far_model
`default_nettype wire

/* File: tb/test_sermap_top.sv */
// Purpose: Self-checking bench for the control-channel mapping block
// Assumes: Watchdog counts shortened to 200 and 50 cycles
// Notes: Bus lines and receiver lock come from sermap_far_model
`default_nettype none
module test_sermap_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, reg_remote = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr_blocked, legacy_compat_mode, low_freq_range, sda_out, scl_out;
    logic mode_pin_compat = 0, mode_pin_lowfreq = 0, sda_raw = 1;
    logic scl_in, sda_in, scl_oe, bus_free, bus_recovering, rx_lock;
    logic [6:0] lock_id, txn_fwd_addr, txn_addr = 7'h00, id_req = 7'h00;
    logic remote_slave_req = 0, remote_slave_grant, txn_start = 0;
    logic txn_fwd, txn_to_des, txn_miss, hang = 0, lock_req = 0;
    int miscompares = 0, n_checks = 0;
    // Clock, 50 ns period
    always #25 ref_clk = ~ref_clk;
    sermap_top #(.WD_LONG(200), .WD_SHORT(50)) i_dut (
        .ref_clk, .rstn, .reg_wr, .reg_rd, .reg_remote, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_wr_blocked, .mode_pin_compat,
        .mode_pin_lowfreq, .legacy_compat_mode, .low_freq_range, .sda_raw,
        .sda_out, .scl_in, .sda_in, .scl_out, .scl_oe, .bus_free,
        .bus_recovering, .rx_lock, .lock_id, .remote_slave_req,
        .remote_slave_grant, .txn_start, .txn_addr, .txn_fwd, .txn_to_des,
        .txn_miss, .txn_fwd_addr
    );
    sermap_far_model i_far (
        .ref_clk, .scl_oe, .hang, .lock_req, .id_req, .scl_in, .sda_in,
        .rx_lock, .lock_id
    );
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic chk8(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    // Bounded wait ran out: report and stop
    task automatic bail(input logic ok);
        chk1(ok, 1'b1);
        if (!ok)
            final_report();
    endtask : bail
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, d, input logic r);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_remote <= r;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_remote <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk8(reg_rdata, e);
    endtask : rdchk
    task automatic txn(input logic [6:0] a, input logic [2:0] e,
        input logic [6:0] ea);
        txn_start <= 1'b1;
        txn_addr <= a;
        @(posedge ref_clk);
        txn_start <= 1'b0;
        @(posedge ref_clk);
        chk8({5'h00, txn_fwd, txn_to_des, txn_miss}, {5'h00, e});
        if (e[2])
            chk8({1'b0, txn_fwd_addr}, {1'b0, ea});
    endtask : txn
    // Reset values, writable masks, unmapped place
    task automatic t_regs;
        rdchk(8'h04, 8'h80);
        for (int i = 5; i < 9; i++)
            rdchk(8'(i), 8'h00);
        wr(8'h05, 8'hff, 1'b0);
        rdchk(8'h05, 8'h1f);
        wr(8'h07, 8'hff, 1'b0);
        rdchk(8'h07, 8'hfe);
        wr(8'h09, 8'h5a, 1'b0);
        rdchk(8'h09, 8'h00);
        wr(8'h05, 8'h00, 1'b0);
    endtask : t_regs
    // Mode source from pins, then from register bits
    task automatic t_mode;
        mode_pin_compat <= 1'b1;
        mode_pin_lowfreq <= 1'b1;
        tick(8);
        chk8({6'h00, legacy_compat_mode, low_freq_range}, 8'h03);
        wr(8'h04, 8'h8a, 1'b0);
        tick(3);
        chk8({6'h00, legacy_compat_mode, low_freq_range}, 8'h00);
        wr(8'h04, 8'h8f, 1'b0);
        mode_pin_compat <= 1'b0;
        mode_pin_lowfreq <= 1'b0;
        tick(8);
        chk8({6'h00, legacy_compat_mode, low_freq_range}, 8'h03);
        wr(8'h04, 8'h80, 1'b0);
        tick(3);
        chk8({6'h00, legacy_compat_mode, low_freq_range}, 8'h00);
    endtask : t_mode
    // Low SDA pulse reaches the output after the coded delay
    task automatic t_delay;
        int n;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h05, 8'(c << 3), 1'b0);
            sda_raw <= 1'b0;
            @(posedge ref_clk);
            sda_raw <= 1'b1;
            n = 0;
            while (sda_out !== 1'b0 && n < 20)
            begin
                @(posedge ref_clk);
                n++;
            end
            chk8(8'(n), 8'((240 + 40 * c + 49) / 50));
        end
        wr(8'h05, 8'h00, 1'b0);
    endtask : t_delay
    // Remote writes refused, local writes and remote slaves still served
    task automatic t_block;
        wr(8'h05, 8'h04, 1'b0);
        wr(8'h07, 8'h22, 1'b1);
        chk1(reg_wr_blocked, 1'b1);
        rdchk(8'h07, 8'hfe);
        wr(8'h05, 8'h00, 1'b1);
        chk1(reg_wr_blocked, 1'b1);
        rdchk(8'h05, 8'h04);
        wr(8'h07, 8'h22, 1'b0);
        chk1(reg_wr_blocked, 1'b0);
        rdchk(8'h07, 8'h22);
        remote_slave_req <= 1'b1;
        tick(2);
        chk1(remote_slave_grant, 1'b1);
        remote_slave_req <= 1'b0;
        wr(8'h05, 8'h00, 1'b0);
        wr(8'h07, 8'h00, 1'b1);
        rdchk(8'h07, 8'h00);
    endtask : t_block
    // Lock autoloads the address unless frozen
    task automatic t_lock;
        id_req <= 7'h2a;
        lock_req <= 1'b1;
        tick(10);
        rdchk(8'h06, 8'h54);
        lock_req <= 1'b0;
        wr(8'h06, 8'h23, 1'b0);
        tick(8);
        lock_req <= 1'b1;
        tick(10);
        rdchk(8'h06, 8'h23);
        lock_req <= 1'b0;
    endtask : t_lock
    // Address matching and alias remapping
    task automatic t_map;
        wr(8'h06, 8'h00, 1'b0);
        txn(7'h00, 3'b001, 7'h00);
        wr(8'h06, 8'h23, 1'b0);
        wr(8'h07, 8'ha0, 1'b0);
        txn(7'h00, 3'b001, 7'h00);
        wr(8'h08, 8'h66, 1'b0);
        txn(7'h33, 3'b100, 7'h50);
        txn(7'h11, 3'b110, 7'h11);
        txn(7'h12, 3'b001, 7'h00);
    endtask : t_map
    // Bus activity, then count quiet cycles until the bus reads free
    task automatic quiet(input int lo, hi);
        int n;
        hang <= 1'b1;
        tick(3);
        hang <= 1'b0;
        tick(8);
        n = 0;
        while (bus_free !== 1'b1 && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
        end
        bail(n < 2000);
        chk1(n >= lo && n <= hi, 1'b1);
    endtask : quiet
    task automatic t_wdog;
        int n, k;
        logic prev, seen;
        wr(8'h05, 8'h02, 1'b0);
        quiet(40, 60);
        wr(8'h05, 8'h00, 1'b0);
        quiet(190, 210);
        wr(8'h05, 8'h02, 1'b0);
        hang <= 1'b1;
        n = 0;
        prev = 1'b0;
        for (k = 0; k < 2500; k++)
        begin
            @(posedge ref_clk);
            n += (scl_oe === 1'b1 && prev === 1'b0) ? 1 : 0;
            prev = scl_oe;
            if (n > 0 && bus_recovering === 1'b0)
                break;
        end
        bail(k < 2500);
        chk8(8'(n), 8'h09);
        chk1(scl_out, 1'b0);
        wr(8'h05, 8'h01, 1'b0);
        seen = 1'b0;
        repeat (300)
        begin
            @(posedge ref_clk);
            seen |= (scl_oe !== 1'b0) || (bus_free !== 1'b0);
        end
        chk1(seen, 1'b0);
        hang <= 1'b0;
    endtask : t_wdog
    // Main sequence
    initial
    begin
        tick(6);
        rstn <= 1'b1;
        tick(3);
        t_regs();
        t_mode();
        t_delay();
        t_block();
        t_lock();
        t_map();
        t_wdog();
        final_report();
    end
endmodule : test_sermap_top
`default_nettype wire

/* File: verilog/sermap_pkg.sv */
// Purpose: Shared constants for the control-channel mapping block
// Assumes: 20 MHz ref_clk, registers reached by byte offset
// Notes: Timing counts derive from the times named here
`default_nettype none
package sermap_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    // Register offsets
    localparam logic [7:0] CFG_OFF = 8'h04;
    localparam logic [7:0] CTRL_OFF = 8'h05;
    localparam logic [7:0] DESA_OFF = 8'h06;
    localparam logic [7:0] PHYS_OFF = 8'h07;
    localparam logic [7:0] ALIAS_OFF = 8'h08;
    // Reset values and writable masks
    localparam logic [7:0] CFG_RST = 8'h80;
    localparam logic [7:0] CFG_MASK = 8'haf;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h1f;
    localparam logic [7:0] ID_RST = 8'h00;
    localparam logic [7:0] ID_MASK = 8'hfe;
    localparam logic [7:0] DESA_MASK = 8'hff;
    // Field positions
    localparam int CFG_COMPAT_SRC = 3;
    localparam int CFG_COMPAT = 2;
    localparam int CFG_LF_SRC = 1;
    localparam int CFG_LF = 0;
    localparam int CTRL_DLY_LO = 3;
    localparam int CTRL_WBLK = 2;
    localparam int CTRL_SPEEDUP = 1;
    localparam int CTRL_WD_OFF = 0;
    localparam int DESA_FREEZE = 0;
    // SDA output delay
    localparam int SDA_BASE_NS = 240;
    localparam int SDA_STEP_NS = 40;
    // Watchdog and recovery timing
    localparam int WD_LONG_MS = 1000;
    localparam int WD_SHORT_MS = 50;
    localparam int WD_LONG_CYC = CLK_HZ / 1000 * WD_LONG_MS;
    localparam int WD_SHORT_CYC = CLK_HZ / 1000 * WD_SHORT_MS;
    localparam int SCL_HALF_US = 5;
    localparam int SCL_HALF_CYC = SCL_HALF_US * (CLK_HZ / 1_000_000);
    localparam int RECOV_PULSES = 9;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_FREE = 2'b01,
        WD_RECOV = 2'b10
    } sermap_wd_e;

    // Cycles of SDA delay for a code, rounded up
    function automatic int sda_cycles(input logic [1:0] code);
        int ns;
        ns = SDA_BASE_NS + SDA_STEP_NS * int'(code);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : sda_cycles
endpackage : sermap_pkg
`default_nettype wire

/* File: verilog/sermap_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk
// Notes: Output changes only when stages two and three agree
`default_nettype none
module sermap_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] filt
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Synchroniser chain
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept bits where the last two stages agree
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            filt <= '0;
        else
            filt <= (s2 & s3) | (filt & (s2 ^ s3));
    end
endmodule : sermap_sync
`default_nettype wire

/* File: verilog/sermap_top.sv */
// Purpose: Control-channel mode select, SDA delay, watchdog, ID mapping
// Assumes: Register port is fed by the serial control bus slave
// Notes: reg_remote marks accesses arriving over the control channel
// How it works
// - Config bit 3 picks compat source
// - Register compat bit enables legacy operation
// - Range source bit picks pin or register
// - Register range bit selects low frequency
// - Two-bit code sets SDA delay steps
// - Block bit rejects remote local writes
// - Remote access to local slaves stays open
// - Watchdog about 1 s, 50 ms sped
// - Disable bit turns watchdog off
// - Quiet high SDA marks bus free
// - Quiet low SDA gets nine SCL pulses
// - Deserializer address zero blocks access
// - Receiver lock autoloads deserializer address
// - Freeze bit keeps written address
// - Alias address remapped to physical address
// - Alias zero disables remote slave access
`default_nettype none
module sermap_top #(
    parameter int WD_LONG = sermap_pkg::WD_LONG_CYC,
    parameter int WD_SHORT = sermap_pkg::WD_SHORT_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_remote,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_wr_blocked,
    input wire logic mode_pin_compat,
    input wire logic mode_pin_lowfreq,
    output logic legacy_compat_mode,
    output logic low_freq_range,
    input wire logic sda_raw,
    output logic sda_out,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic bus_free,
    output logic bus_recovering,
    input wire logic rx_lock,
    input wire logic [6:0] lock_id,
    input wire logic remote_slave_req,
    output logic remote_slave_grant,
    input wire logic txn_start,
    input wire logic [6:0] txn_addr,
    output logic txn_fwd,
    output logic txn_to_des,
    output logic txn_miss,
    output logic [6:0] txn_fwd_addr
);
    logic [1:0] rst_ff;
    logic rst_n_s;
    logic [4:0] pins_s;
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [7:0] desa;
    logic [7:0] phys;
    logic [7:0] alias_id;
    logic wr_ok;
    logic lock_q;
    logic lock_rise;
    logic [6:0] sh;
    logic [1:0] dly_code;
    logic hit_des;
    logic hit_alias;
    logic [6:0] deserializer_address;
    logic [6:0] remote_slave_alias;
    logic [6:0] remote_slave_physical;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rst_ff <= 2'h0;
        else
            rst_ff <= {rst_ff[0], 1'b1};
    end
    assign rst_n_s = rst_ff[1];

    // Pin synchronisers: compat, lowfreq, scl, sda, lock
    sermap_sync #(
        .W(5)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n_s),
        .pin({mode_pin_compat, mode_pin_lowfreq, scl_in, sda_in, rx_lock}),
        .filt(pins_s)
    );

    // Field views
    assign deserializer_address = desa[7:1];
    assign remote_slave_alias = alias_id[7:1];
    assign remote_slave_physical = phys[7:1];
    assign dly_code = ctrl[sermap_pkg::CTRL_DLY_LO +: 2];

    // Offsets used by the write-block and freeze checks
    localparam logic [7:0] CTRL_OFF_C = sermap_pkg::CTRL_OFF;
    localparam logic [7:0] DESA_OFF_C = sermap_pkg::DESA_OFF;

    // block remote writes to own registers
    assign wr_ok = reg_wr && !(reg_remote && ctrl[sermap_pkg::CTRL_WBLK]);

    // Mode and I2C control registers
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            cfg <= sermap_pkg::CFG_RST;
            ctrl <= sermap_pkg::CTRL_RST;
        end
        else if (wr_ok)
        begin
            if (reg_addr == sermap_pkg::CFG_OFF)
                cfg <= reg_wdata & sermap_pkg::CFG_MASK;
            if (reg_addr == sermap_pkg::CTRL_OFF)
                ctrl <= reg_wdata & sermap_pkg::CTRL_MASK;
        end
    end

    // Remote slave physical and alias registers
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            phys <= sermap_pkg::ID_RST;
            alias_id <= sermap_pkg::ID_RST;
        end
        else if (wr_ok)
        begin
            if (reg_addr == sermap_pkg::PHYS_OFF)
                phys <= reg_wdata & sermap_pkg::ID_MASK;
            if (reg_addr == sermap_pkg::ALIAS_OFF)
                alias_id <= reg_wdata & sermap_pkg::ID_MASK;
        end
    end

    // Lock edge detect on the filtered lock level
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            lock_q <= 1'b0;
        else
            lock_q <= pins_s[0];
    end
    assign lock_rise = pins_s[0] && !lock_q;

    // autoload on lock, wins over a write
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            desa <= sermap_pkg::ID_RST;
        else if (lock_rise && !desa[sermap_pkg::DESA_FREEZE])
            desa[7:1] <= lock_id;
        else if (wr_ok && reg_addr == sermap_pkg::DESA_OFF)
            desa <= reg_wdata & sermap_pkg::DESA_MASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            reg_wr_blocked <= 1'b0;
        else
            reg_wr_blocked <= reg_wr && !wr_ok;
    end

    // Register read data, unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                sermap_pkg::CFG_OFF: reg_rdata <= cfg;
                sermap_pkg::CTRL_OFF: reg_rdata <= ctrl;
                sermap_pkg::DESA_OFF: reg_rdata <= desa;
                sermap_pkg::PHYS_OFF: reg_rdata <= phys;
                sermap_pkg::ALIAS_OFF: reg_rdata <= alias_id;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            legacy_compat_mode <= 1'b0;
            low_freq_range <= 1'b0;
        end
        else
        begin
            legacy_compat_mode <= cfg[sermap_pkg::CFG_COMPAT_SRC]
                ? cfg[sermap_pkg::CFG_COMPAT] : pins_s[4];
            low_freq_range <= cfg[sermap_pkg::CFG_LF_SRC]
                ? cfg[sermap_pkg::CFG_LF] : pins_s[3];
        end
    end

    // SDA delay line with selectable tap
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            sh <= 7'h7f;
            sda_out <= 1'b1;
        end
        else
        begin
            // Stage k holds the drive value from k+1 cycles back
            sh <= {sh[5:0], sda_raw};
            sda_out <= sh[3'(sermap_pkg::sda_cycles(dly_code) - 2)];
        end
    end

    // Watchdog on the synchronised bus lines
    sermap_watchdog #(
        .LONG_CYC(WD_LONG),
        .SHORT_CYC(WD_SHORT),
        .HALF_CYC(sermap_pkg::SCL_HALF_CYC)
    ) u_wd (
        .ref_clk(ref_clk),
        .rst_n(rst_n_s),
        .scl_i(pins_s[2]),
        .sda_i(pins_s[1]),
        .wd_off(ctrl[sermap_pkg::CTRL_WD_OFF]),
        .speedup(ctrl[sermap_pkg::CTRL_SPEEDUP]),
        .bus_free(bus_free),
        .recovering(bus_recovering),
        .scl_oe(scl_oe)
    );
    assign scl_out = 1'b0; // Open drain, only pulls low

    // remote reach to local slaves ignores the block bit
    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            remote_slave_grant <= 1'b0;
        else
            remote_slave_grant <= remote_slave_req;
    end

    assign hit_des = (deserializer_address != 7'h00)
        && (txn_addr == deserializer_address);
    assign hit_alias = (remote_slave_alias != 7'h00)
        && (txn_addr == remote_slave_alias);

    always_ff @(posedge ref_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            txn_fwd <= 1'b0;
            txn_to_des <= 1'b0;
            txn_miss <= 1'b0;
            txn_fwd_addr <= 7'h00;
        end
        else
        begin
            txn_fwd <= txn_start && (hit_des || hit_alias);
            txn_to_des <= txn_start && hit_des;
            txn_miss <= txn_start && !hit_des && !hit_alias;
            if (txn_start)
                txn_fwd_addr <= (hit_alias && !hit_des)
                    ? remote_slave_physical : txn_addr;
        end
    end

    sequence s_alias_req;
        txn_start && hit_alias && !hit_des;
    endsequence
    sequence s_alias_fwd;
        txn_fwd && !txn_to_des && txn_fwd_addr == $past(remote_slave_physical);
    endsequence

    a_compat_src: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        ##1 legacy_compat_mode == ($past(cfg[3]) ? $past(cfg[2])
        : $past(pins_s[4])))
        else $error("compat mode source wrong");
    a_compat_reg: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        (cfg[3] && !cfg[2]) [*2] |-> !legacy_compat_mode)
        else $error("compat mode on while register bit clear");
    a_range_src: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        (cfg[1] && cfg[0]) [*2] |-> low_freq_range)
        else $error("register range not applied");
    a_range_pin: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        !cfg[1] ##1 !cfg[1] |-> low_freq_range == $past(pins_s[3]))
        else $error("pin range not applied");
    a_sda_delay: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        (dly_code == 2'h0) [*8] |-> sda_out == $past(sda_raw, 5))
        else $error("SDA delay not five cycles");
    a_sda_long: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        (dly_code == 2'h3) [*8] |-> sda_out == $past(sda_raw, 8))
        else $error("SDA delay not eight cycles");
    a_write_block: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        reg_wr && reg_remote && ctrl[2] && reg_addr == CTRL_OFF_C
        |=> reg_wr_blocked && $stable(ctrl))
        else $error("remote write not blocked");
    a_slave_open: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        remote_slave_req |=> remote_slave_grant)
        else $error("remote slave access lost");
    a_des_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        txn_start && deserializer_address == 7'h00 && !hit_alias
        |=> !txn_fwd && txn_miss)
        else $error("forward with zero deserializer address");
    a_autoload: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        lock_rise && !desa[0] |=> desa[7:1] == $past(lock_id))
        else $error("deserializer address not autoloaded");
    a_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        desa[0] && !(reg_wr && reg_addr == DESA_OFF_C) |=> $stable(desa))
        else $error("frozen address changed");
    a_alias_map: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        s_alias_req |=> s_alias_fwd)
        else $error("alias not remapped");
    a_alias_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        txn_start && remote_slave_alias == 7'h00 && !hit_des
        |=> !txn_fwd)
        else $error("forward with zero alias");
    a_fwd_match: assert property (@(posedge ref_clk) disable iff (!rst_n_s)
        txn_fwd |-> $past(txn_start) && $past(txn_addr) != 7'h00)
        else $error("forward without a match");

endmodule : sermap_top
`default_nettype wire

/* File: verilog/sermap_watchdog.sv */
// Purpose: I2C bus watchdog, free-bus detect and hung-bus recovery
// Assumes: scl_i and sda_i already synchronised
// Notes: Own SCL drive is not counted as bus activity
`default_nettype none
module sermap_watchdog #(
    parameter int LONG_CYC = sermap_pkg::WD_LONG_CYC,
    parameter int SHORT_CYC = sermap_pkg::WD_SHORT_CYC,
    parameter int HALF_CYC = sermap_pkg::SCL_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic wd_off,
    input wire logic speedup,
    output logic bus_free,
    output logic recovering,
    output logic scl_oe
);
    localparam int CW = $clog2(LONG_CYC + 1);
    localparam int HW = $clog2(HALF_CYC + 1);
    localparam logic [4:0] LAST_PH = 5'(2 * sermap_pkg::RECOV_PULSES - 1);
    sermap_pkg::sermap_wd_e state;
    logic [CW-1:0] cnt;
    logic [HW-1:0] half;
    logic [4:0] ph;
    logic scl_q;
    logic sda_q;
    logic activity;
    logic [CW-1:0] limit;

    assign activity = (scl_i != scl_q) || (sda_i != sda_q);
    assign limit = speedup ? CW'(SHORT_CYC) : CW'(LONG_CYC);
    assign bus_free = (state == sermap_pkg::WD_FREE);
    assign recovering = (state == sermap_pkg::WD_RECOV);

    // Previous line levels for activity detection
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= sermap_pkg::WD_IDLE;
            cnt <= '0;
            half <= '0;
            ph <= '0;
            scl_oe <= 1'b0;
        end
        else if (wd_off)
        begin
            state <= sermap_pkg::WD_IDLE;
            cnt <= '0;
            scl_oe <= 1'b0;
        end
        else
        begin
            unique case (state)
                sermap_pkg::WD_IDLE:
                begin
                    if (activity)
                        cnt <= '0;
                    else if (cnt >= limit - CW'(1))
                    begin
                        cnt <= '0;
                        half <= '0;
                        ph <= '0;
                        state <= sda_i ? sermap_pkg::WD_FREE
                                       : sermap_pkg::WD_RECOV;
                        scl_oe <= !sda_i;
                    end
                    else
                        cnt <= cnt + CW'(1);
                end
                sermap_pkg::WD_FREE:
                begin
                    if (activity)
                        state <= sermap_pkg::WD_IDLE;
                end
                sermap_pkg::WD_RECOV:
                begin
                    if (half == HW'(HALF_CYC - 1))
                    begin
                        half <= '0;
                        if (ph == LAST_PH)
                        begin
                            state <= sermap_pkg::WD_IDLE;
                            scl_oe <= 1'b0;
                        end
                        else
                        begin
                            ph <= ph + 5'h01;
                            scl_oe <= !scl_oe;
                        end
                    end
                    else
                        half <= half + HW'(1);
                end
                default:
                    state <= sermap_pkg::WD_IDLE;
            endcase
        end
    end

    a_wd_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_off |=> !scl_oe && !bus_free)
        else $error("watchdog active while disabled");
    a_free_sda_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(bus_free) |-> $past(sda_i))
        else $error("bus free declared with SDA low");
    a_drive_recov: assert property (@(posedge ref_clk) disable iff (!rst_n)
        scl_oe |-> recovering)
        else $error("SCL driven outside recovery");
endmodule : sermap_watchdog
`default_nettype wire
